//--- hdl/power_clock_reset_manager.sv
// power, clock and reset manager with its axi4-lite register slave
module power_clock_reset_manager
  import power_clock_reset_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire reset_src_t reset_src,
  input wire sleep_ctl_t sleep_ctl,
  input wire logic [NUM_OSC-1:0] osc_keep_in_standby,
  input wire logic [NUM_OSC-1:0] osc_run_on_request,
  input wire logic [NUM_OSC-1:0] osc_request,
  input wire logic generic_clock_unit_request,
  output domain_rst_t domain_rst,
  output clk_en_t clk_en,
  output power_state_t power_state,
  output logic irq
);

  pm_state_t q;
  pm_state_t d;

  function automatic logic div_tick(input logic [PRE_W-1:0] cnt, input logic [DIV_W-1:0] sel);
    logic [PRE_W-1:0] m;
    m = PRE_W'((PRE_ONE << sel) - PRE_ONE);
    return (cnt & m) == m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] adr(input logic [7:0] idx);
    return {idx, ADDR_LSB};
  endfunction

  logic rst_any;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic mask_lock;
  logic sel_write;
  logic apply;
  logic wake_idle;
  logic sleep_req;
  logic cpu_run;
  logic ahb_run;
  logic apb_run;
  logic [PRE_W-1:0] cnt_n;
  logic [31:0] wd;
  logic [31:0] rd;
  logic rd_ok;
  logic wr_ok;
  logic [ADDR_W-1:0] wa;

  assign s_axi_awready = ~q.aw_held;
  assign s_axi_wready = ~q.w_held;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign domain_rst = q.rst;
  assign clk_en = q.clk;
  assign power_state = q.pwr;
  assign irq = q.irq_flag & q.irq_enable;

  assign aw_hs = s_axi_awvalid & ~q.aw_held;
  assign w_hs = s_axi_wvalid & ~q.w_held;
  assign ar_hs = s_axi_arvalid & ~q.rvalid;
  assign do_write = q.aw_held & q.w_held & ~q.bvalid;
  assign wa = q.aw_addr;
  // manager's own bus clock or its bridge masked off: masks frozen
  assign mask_lock = ~q.bus_a_gate_mask[APBA_SELF_BIT] | ~q.fast_bus_clock_gate_mask[AHB_BRIDGE_A_BIT];
  assign rst_any = reset_src.por | reset_src.core_brownout_source | reset_src.supply_brownout_source
    | ~reset_src.ext_reset_n | reset_src.watchdog_timer | reset_src.cpu_soft_reset_request;

  always_comb begin
    rd = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      adr(IDX_SLEEP): rd[1:0] = q.idle_level;
      adr(IDX_CPU_SEL): rd[DIV_W-1:0] = q.cpu_clock_select;
      adr(IDX_BUSA_SEL): rd[DIV_W-1:0] = q.bus_clock_select[0 +: DIV_W];
      adr(IDX_BUSB_SEL): rd[DIV_W-1:0] = q.bus_clock_select[DIV_W +: DIV_W];
      adr(IDX_BUSC_SEL): rd[DIV_W-1:0] = q.bus_clock_select[2*DIV_W +: DIV_W];
      adr(IDX_FAST_MASK): rd[AHB_W-1:0] = q.fast_bus_clock_gate_mask;
      adr(IDX_BUSA_MASK): rd[APBA_W-1:0] = q.bus_a_gate_mask;
      adr(IDX_BUSB_MASK): rd[APBB_W-1:0] = q.bus_b_gate_mask;
      adr(IDX_BUSC_MASK): rd[APBC_W-1:0] = q.bus_c_gate_mask;
      adr(IDX_IRQ_CLR), adr(IDX_IRQ_SET): rd[0] = q.irq_enable;
      adr(IDX_IRQ_FLAG): rd[0] = q.irq_flag;
      adr(IDX_ORIGIN): rd[RC_W-1:0] = q.reset_origin_record;
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (wa)
      adr(IDX_SLEEP), adr(IDX_CPU_SEL), adr(IDX_BUSA_SEL), adr(IDX_BUSB_SEL), adr(IDX_BUSC_SEL),
      adr(IDX_FAST_MASK), adr(IDX_BUSA_MASK), adr(IDX_BUSB_MASK), adr(IDX_BUSC_MASK),
      adr(IDX_IRQ_CLR), adr(IDX_IRQ_SET), adr(IDX_IRQ_FLAG), adr(IDX_ORIGIN): wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    wd = merge(32'h0, q.w_data, q.w_strb);
    sel_write = 1'b0;

    // bus channels
    if (aw_hs) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid & s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid & s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    if (do_write) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (q.w_strb[0]) begin
        unique case (wa)
          adr(IDX_SLEEP): begin
            if (wd[1:0] != IDLE_RESERVED) begin
              d.idle_level = wd[1:0];
            end
          end
          adr(IDX_CPU_SEL): begin
            d.cpu_clock_select = wd[DIV_W-1:0];
            sel_write = 1'b1;
          end
          adr(IDX_BUSA_SEL): begin
            d.bus_clock_select[0 +: DIV_W] = wd[DIV_W-1:0];
            sel_write = 1'b1;
          end
          adr(IDX_BUSB_SEL): begin
            d.bus_clock_select[DIV_W +: DIV_W] = wd[DIV_W-1:0];
            sel_write = 1'b1;
          end
          adr(IDX_BUSC_SEL): begin
            d.bus_clock_select[2*DIV_W +: DIV_W] = wd[DIV_W-1:0];
            sel_write = 1'b1;
          end
          adr(IDX_IRQ_SET): d.irq_enable = q.irq_enable | wd[0];
          adr(IDX_IRQ_CLR): d.irq_enable = q.irq_enable & ~wd[0];
          adr(IDX_IRQ_FLAG): d.irq_flag = q.irq_flag & ~wd[0];
          default: ;
        endcase
      end
      if (!mask_lock) begin
        unique case (wa)
          adr(IDX_FAST_MASK): d.fast_bus_clock_gate_mask =
            AHB_W'(merge(32'(q.fast_bus_clock_gate_mask), q.w_data, q.w_strb));
          adr(IDX_BUSA_MASK): d.bus_a_gate_mask = APBA_W'(merge(32'(q.bus_a_gate_mask), q.w_data, q.w_strb));
          adr(IDX_BUSB_MASK): d.bus_b_gate_mask = APBB_W'(merge(32'(q.bus_b_gate_mask), q.w_data, q.w_strb));
          adr(IDX_BUSC_MASK): d.bus_c_gate_mask = APBC_W'(merge(32'(q.bus_c_gate_mask), q.w_data, q.w_strb));
          default: ;
        endcase
      end
    end

    // prescaler: new setting applies only on the common wrap so all clocks stay aligned
    apply = q.settle_pending & (q.pre_cnt == PRE_LAST);
    if (apply) begin
      d.cpu_div_eff = q.cpu_clock_select;
      d.bus_div_eff = q.bus_clock_select;
      d.settle_pending = 1'b0;
    end
    if (sel_write) begin
      d.settle_pending = 1'b1;
      d.irq_flag = 1'b0;
    end
    if (apply) begin
      d.irq_flag = 1'b1;
    end
    cnt_n = PRE_W'(q.pre_cnt + PRE_ONE);
    d.pre_cnt = cnt_n;

    // sleep mode controller
    sleep_req = sleep_ctl.wait_for_interrupt_instr
      | (sleep_ctl.handler_return & sleep_ctl.sleep_after_handler);
    wake_idle = sleep_ctl.wake_async_irq
      | (sleep_ctl.wake_apb_irq & (q.idle_level != IDLE_APB))
      | (sleep_ctl.wake_ahb_irq & (q.idle_level == IDLE_CPU));
    unique case (q.pwr.mode)
      MODE_ACTIVE: begin
        if (sleep_req) begin
          d.pwr.mode = sleep_ctl.deep_sleep_select ? MODE_STANDBY : MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (wake_idle) begin
          d.pwr.mode = MODE_ACTIVE;
        end
      end
      MODE_STANDBY: begin
        if (sleep_ctl.wake_async_irq) begin
          d.pwr.mode = MODE_ACTIVE;
        end
      end
      default: d.pwr.mode = MODE_ACTIVE;
    endcase

    // domain clocks follow the mode being entered
    cpu_run = d.pwr.mode == MODE_ACTIVE;
    ahb_run = cpu_run | ((d.pwr.mode == MODE_IDLE) & (q.idle_level == IDLE_CPU));
    apb_run = cpu_run | ((d.pwr.mode == MODE_IDLE) & (q.idle_level != IDLE_APB));
    d.clk.cpu_clk_en = cpu_run & div_tick(cnt_n, d.cpu_div_eff);
    // per-module gates: mask bit and running domain both needed
    d.clk.fast_bus_clk_en = {AHB_W{ahb_run & div_tick(cnt_n, d.cpu_div_eff)}}
      & q.fast_bus_clock_gate_mask;
    d.clk.bus_a_clk_en = {APBA_W{apb_run & div_tick(cnt_n, d.bus_div_eff[0 +: DIV_W])}}
      & q.bus_a_gate_mask;
    d.clk.bus_b_clk_en = {APBB_W{apb_run & div_tick(cnt_n, d.bus_div_eff[DIV_W +: DIV_W])}}
      & q.bus_b_gate_mask;
    d.clk.bus_c_clk_en = {APBC_W{apb_run & div_tick(cnt_n, d.bus_div_eff[2*DIV_W +: DIV_W])}}
      & q.bus_c_gate_mask;

    // standby power and oscillators
    d.pwr.main_clk_run = d.pwr.mode != MODE_STANDBY;
    d.pwr.regulator_low_power = d.pwr.mode == MODE_STANDBY;
    d.pwr.ram_low_power = d.pwr.mode == MODE_STANDBY;
    d.pwr.generic_clock_unit_run = (d.pwr.mode != MODE_STANDBY) | generic_clock_unit_request;
    for (int i = 0; i < NUM_OSC; i++) begin
      d.pwr.osc_run[i] = (~osc_run_on_request[i] | osc_request[i])
        & ((d.pwr.mode != MODE_STANDBY) | osc_keep_in_standby[i]);
    end

    // reset controller
    d.rst.backup_rst = reset_src.por | reset_src.core_brownout_source | reset_src.supply_brownout_source;
    d.rst.debug_rst = d.rst.backup_rst | ~reset_src.ext_reset_n;
    d.rst.system_rst = rst_any;
    if (rst_any) begin
      d.idle_level = IDLE_CPU;
      d.cpu_clock_select = '0;
      d.bus_clock_select = '0;
      d.cpu_div_eff = '0;
      d.bus_div_eff = '0;
      d.settle_pending = 1'b0;
      d.pre_cnt = '0;
      d.fast_bus_clock_gate_mask = AHB_RESET;
      d.bus_a_gate_mask = APBA_RESET;
      d.bus_b_gate_mask = APBB_RESET;
      d.bus_c_gate_mask = APBC_RESET;
      d.irq_enable = 1'b0;
      d.irq_flag = 1'b0;
      d.pwr.mode = MODE_ACTIVE;
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b0;
      d.rvalid = 1'b0;
      d.reset_origin_record = '0;
      if (reset_src.por) begin
        d.reset_origin_record[RC_POR] = 1'b1;
      end else if (reset_src.core_brownout_source) begin
        d.reset_origin_record[RC_CORE_BOD] = 1'b1;
      end else if (reset_src.supply_brownout_source) begin
        d.reset_origin_record[RC_SUPPLY_BOD] = 1'b1;
      end else if (!reset_src.ext_reset_n) begin
        d.reset_origin_record[RC_EXT] = 1'b1;
      end else if (reset_src.watchdog_timer) begin
        d.reset_origin_record[RC_DOG] = 1'b1;
      end else begin
        d.reset_origin_record[RC_SOFT] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.fast_bus_clock_gate_mask <= AHB_RESET;
      q.bus_a_gate_mask <= APBA_RESET;
      q.bus_b_gate_mask <= APBB_RESET;
      q.bus_c_gate_mask <= APBC_RESET;
      q.reset_origin_record <= RC_RESET;
      q.pwr.mode <= MODE_ACTIVE;
      q.pwr.main_clk_run <= 1'b1;
      q.pwr.generic_clock_unit_run <= 1'b1;
      q.rst.backup_rst <= 1'b1;
      q.rst.debug_rst <= 1'b1;
      q.rst.system_rst <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule

//--- hdl/power_clock_reset_pkg.sv
// constants, types and state layout of the power, clock and reset manager
package power_clock_reset_pkg;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_SLEEP = 8'h01;
  localparam logic [7:0] IDX_CPU_SEL = 8'h08;
  localparam logic [7:0] IDX_BUSA_SEL = 8'h09;
  localparam logic [7:0] IDX_BUSB_SEL = 8'h0a;
  localparam logic [7:0] IDX_BUSC_SEL = 8'h0b;
  localparam logic [7:0] IDX_FAST_MASK = 8'h14;
  localparam logic [7:0] IDX_BUSA_MASK = 8'h18;
  localparam logic [7:0] IDX_BUSB_MASK = 8'h1c;
  localparam logic [7:0] IDX_BUSC_MASK = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h34;
  localparam logic [7:0] IDX_IRQ_SET = 8'h35;
  localparam logic [7:0] IDX_IRQ_FLAG = 8'h36;
  localparam logic [7:0] IDX_ORIGIN = 8'h38;
  localparam int unsigned ADDR_W = 10;
  localparam logic [1:0] ADDR_LSB = 2'b00;

  localparam int unsigned DIV_W = 3;
  localparam int unsigned PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = 7'h7f;
  localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;

  localparam int unsigned AHB_W = 6;
  localparam int unsigned APBA_W = 7;
  localparam int unsigned APBB_W = 5;
  localparam int unsigned APBC_W = 20;
  // fast bus: bridge0..2, debug, flash controller, transfer engine
  localparam logic [AHB_W-1:0] AHB_RESET = 6'h3f;
  // bus A: protect0, power manager, sysctrl, generic clock, watchdog, rtc, ext irq
  localparam logic [APBA_W-1:0] APBA_RESET = 7'h7f;
  // bus B: protect1, debug, flash controller, port, transfer engine
  localparam logic [APBB_W-1:0] APBB_RESET = 5'h1f;
  // bus C: only the converter enabled
  localparam logic [APBC_W-1:0] APBC_RESET = 20'h10000;
  localparam int unsigned APBA_SELF_BIT = 1;
  localparam int unsigned AHB_BRIDGE_A_BIT = 0;

  localparam int unsigned RC_POR = 0;
  localparam int unsigned RC_CORE_BOD = 1;
  localparam int unsigned RC_SUPPLY_BOD = 2;
  localparam int unsigned RC_EXT = 4;
  localparam int unsigned RC_DOG = 5;
  localparam int unsigned RC_SOFT = 6;
  localparam int unsigned RC_W = 7;
  localparam logic [RC_W-1:0] RC_RESET = 7'h01;

  localparam int unsigned NUM_OSC = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    IDLE_CPU = 2'b00,
    IDLE_AHB = 2'b01,
    IDLE_APB = 2'b10
  } idle_level_t;
  localparam logic [1:0] IDLE_RESERVED = 2'b11;

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_STANDBY = 2'b10
  } pm_mode_t;

  typedef struct packed {
    logic por;
    logic core_brownout_source;
    logic supply_brownout_source;
    logic ext_reset_n;
    logic watchdog_timer;
    logic cpu_soft_reset_request;
  } reset_src_t;

  typedef struct packed {
    logic backup_rst;
    logic debug_rst;
    logic system_rst;
  } domain_rst_t;

  typedef struct packed {
    logic wait_for_interrupt_instr;
    logic handler_return;
    logic sleep_after_handler;
    logic deep_sleep_select;
    logic wake_apb_irq;
    logic wake_ahb_irq;
    logic wake_async_irq;
  } sleep_ctl_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic [AHB_W-1:0] fast_bus_clk_en;
    logic [APBA_W-1:0] bus_a_clk_en;
    logic [APBB_W-1:0] bus_b_clk_en;
    logic [APBC_W-1:0] bus_c_clk_en;
  } clk_en_t;

  typedef struct packed {
    pm_mode_t mode;
    logic main_clk_run;
    logic regulator_low_power;
    logic ram_low_power;
    logic generic_clock_unit_run;
    logic [NUM_OSC-1:0] osc_run;
  } power_state_t;

  typedef struct packed {
    logic [1:0] idle_level;
    logic [DIV_W-1:0] cpu_clock_select;
    logic [3*DIV_W-1:0] bus_clock_select;
    logic [DIV_W-1:0] cpu_div_eff;
    logic [3*DIV_W-1:0] bus_div_eff;
    logic settle_pending;
    logic [PRE_W-1:0] pre_cnt;
    logic [AHB_W-1:0] fast_bus_clock_gate_mask;
    logic [APBA_W-1:0] bus_a_gate_mask;
    logic [APBB_W-1:0] bus_b_gate_mask;
    logic [APBC_W-1:0] bus_c_gate_mask;
    logic irq_enable;
    logic irq_flag;
    logic [RC_W-1:0] reset_origin_record;
    domain_rst_t rst;
    clk_en_t clk;
    power_state_t pwr;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pm_state_t;
endpackage

//--- sim/cpu_side_model.sv
// stand-in for cpu core and reset sources on the far side of the manager
module cpu_side_model
  import power_clock_reset_pkg::*;
(
  input wire logic aclk,
  input wire logic [2:0] src_sel,
  input wire logic wfi_go,
  input wire logic ret_go,
  input wire logic [4:0] cfg,
  output reset_src_t reset_src,
  output sleep_ctl_t sleep_ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wfi_q;
  logic ret_q;
  always_ff @(posedge aclk) begin
    wfi_q <= wfi_go;
    ret_q <= ret_go;
  end
  assign reset_src.por = src_sel == 3'd1;
  assign reset_src.core_brownout_source = src_sel == 3'd2;
  assign reset_src.supply_brownout_source = src_sel == 3'd3;
  // pin pulled up unless pulled low
  assign reset_src.ext_reset_n = src_sel != 3'd4;
  assign reset_src.watchdog_timer = src_sel == 3'd5;
  assign reset_src.cpu_soft_reset_request = src_sel == 3'd6;
  // single-cycle instruction pulses, depth set on the same clock edge
  assign sleep_ctl.wait_for_interrupt_instr = wfi_go & ~wfi_q;
  assign sleep_ctl.handler_return = ret_go & ~ret_q;
  assign sleep_ctl.sleep_after_handler = cfg[4];
  assign sleep_ctl.deep_sleep_select = cfg[3];
  assign sleep_ctl.wake_apb_irq = cfg[2];
  assign sleep_ctl.wake_ahb_irq = cfg[1];
  assign sleep_ctl.wake_async_irq = cfg[0];
endmodule

//--- sim/pcrm_monitor.sv
// port checker for reset domains, sleep modes and standby behaviour
module pcrm_monitor
  import power_clock_reset_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire reset_src_t reset_src,
  input wire sleep_ctl_t sleep_ctl,
  input wire logic generic_clock_unit_request,
  input wire domain_rst_t domain_rst,
  input wire clk_en_t clk_en,
  input wire power_state_t power_state,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic pwr_src;
  logic usr_src;
  logic stby;
  assign pwr_src = reset_src.por | reset_src.core_brownout_source | reset_src.supply_brownout_source;
  assign usr_src = !reset_src.ext_reset_n | reset_src.watchdog_timer | reset_src.cpu_soft_reset_request;
  assign stby = power_state.mode == MODE_STANDBY;
  chk_power_all_domains: assert property (pwr_src |=> domain_rst == 3'b111)
    else $error("power reset left a domain running");
  chk_ext_spare_backup: assert property (!pwr_src && !reset_src.ext_reset_n |=> domain_rst == 3'b011)
    else $error("external reset domains wrong");
  chk_user_spare_debug: assert property (!pwr_src && reset_src.ext_reset_n && usr_src |=> domain_rst == 3'b001)
    else $error("user reset domains wrong");
  chk_reset_drops_irq: assert property (pwr_src || usr_src |=> !irq)
    else $error("irq survived a reset");
  chk_sleep_cpu_stop: assert property (power_state.mode != MODE_ACTIVE |-> !clk_en.cpu_clk_en)
    else $error("cpu clock ran while asleep");
  chk_idle_stays_normal: assert property (power_state.mode == MODE_IDLE |->
    power_state.main_clk_run && !power_state.regulator_low_power && !power_state.ram_low_power)
    else $error("idle changed main clock or regulator");
  chk_standby_low_power: assert property (stby |-> !power_state.main_clk_run && power_state.ram_low_power
    && power_state.regulator_low_power && clk_en.fast_bus_clk_en == 6'h00)
    else $error("standby power state wrong");
  chk_async_wake_ends: assert property (stby && sleep_ctl.wake_async_irq |-> ##[1:4]
    power_state.mode == MODE_ACTIVE)
    else $error("async wake did not end standby");
  chk_sleepwalk_generic_clock_unit: assert property (stby && generic_clock_unit_request && !sleep_ctl.wake_async_irq |=>
    power_state.generic_clock_unit_run || !stby)
    else $error("generic clock not restarted in standby");
  chk_wfi_deep_entry: assert property (power_state.mode == MODE_ACTIVE && sleep_ctl.wait_for_interrupt_instr
    && sleep_ctl.deep_sleep_select && !sleep_ctl.wake_async_irq && !pwr_src && !usr_src |-> ##[1:3] stby)
    else $error("deep wait did not enter standby");
endmodule

bind power_clock_reset_manager pcrm_monitor i_pcrm_monitor (.aclk(aclk), .aresetn(aresetn),
  .reset_src(reset_src), .sleep_ctl(sleep_ctl), .generic_clock_unit_request(generic_clock_unit_request), .domain_rst(domain_rst),
  .clk_en(clk_en), .power_state(power_state), .irq(irq));

//--- sim/tb_top.sv
// self-checking bench of the power, clock and reset manager
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) begin \
      errors++; \
      $display("BAD %0t mismatch %0h %0h", $time, (a), (b)); \
    end \
  end
module tb_top;
  import power_clock_reset_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] src_sel;
  logic wfi_go, ret_go, generic_clock_unit_req, irq;
  logic [4:0] cfg;
  logic [3:0] keep, ondem, oreq;
  reset_src_t reset_src;
  sleep_ctl_t sleep_ctl;
  domain_rst_t domain_rst;
  clk_en_t clk_en;
  power_state_t ps;
  int errors, num_checks;
  power_clock_reset_manager i_power_clock_reset_manager (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reset_src(reset_src),
    .sleep_ctl(sleep_ctl), .osc_keep_in_standby(keep), .osc_run_on_request(ondem), .osc_request(oreq),
    .generic_clock_unit_request(generic_clock_unit_req), .domain_rst(domain_rst), .clk_en(clk_en), .power_state(ps), .irq(irq));
  cpu_side_model i_cpu_side_model (.aclk(aclk), .src_sel(src_sel), .wfi_go(wfi_go), .ret_go(ret_go),
    .cfg(cfg), .reset_src(reset_src), .sleep_ctl(sleep_ctl));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic complete_run();
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(inout int n);
    n++;
    if (n > 3000) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge aclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    logic ad, dd;
    int n;
    ad = 1'b0;
    dd = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= {idx, ADDR_LSB};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge aclk);
      step(n);
      ad = ad | awready;
      dd = dd | wready;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      step(n);
    end while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      step(n);
    end while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      step(n);
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic wait_mode(input pm_mode_t m);
    int n;
    n = 0;
    while (ps.mode !== m) begin
      @(negedge aclk);
      step(n);
    end
  endtask
  task automatic pulse_wfi(input logic [4:0] c);
    @(posedge aclk);
    cfg <= c;
    wfi_go <= 1'b1;
    @(posedge aclk);
    wfi_go <= 1'b0;
  endtask
  task automatic t_defaults();
    rd({IDX_FAST_MASK, ADDR_LSB});
    `CHK(d, 32'h0000003f)
    rd({IDX_BUSB_MASK, ADDR_LSB});
    `CHK(d, 32'h0000001f)
    rd({IDX_BUSC_MASK, ADDR_LSB});
    `CHK(d, 32'h00010000)
    rd({IDX_ORIGIN, ADDR_LSB});
    `CHK(d, 32'h00000001)
    rd(10'h3fc);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    `CHK({clk_en.fast_bus_clk_en, clk_en.bus_c_clk_en}, {AHB_RESET, APBC_RESET})
  endtask
  task automatic t_masks();
    wr(IDX_BUSC_MASK, 32'h3);
    wr(IDX_BUSB_MASK, 32'hf);
    cyc(2);
    `CHK(clk_en.bus_c_clk_en, 20'h00003)
    `CHK({clk_en.fast_bus_clk_en[5], clk_en.bus_b_clk_en}, 6'h2f)
    wr(IDX_BUSA_MASK, 32'h7d);
    wr(IDX_BUSC_MASK, 32'hff);
    rd({IDX_BUSC_MASK, ADDR_LSB});
    `CHK(d, 32'h3)
    @(posedge aclk);
    src_sel <= 3'd4;
    repeat (2) @(posedge aclk);
    src_sel <= 3'd0;
    rd({IDX_BUSA_MASK, ADDR_LSB});
    `CHK(d, 32'h7f)
  endtask
  task automatic t_settle();
    int k, p;
    k = 0;
    p = 0;
    wr(IDX_IRQ_SET, 32'h1);
    wr(IDX_IRQ_FLAG, 32'h1);
    `CHK(irq, 1'b0)
    wr(IDX_CPU_SEL, 32'h3);
    while (irq !== 1'b1) begin
      @(negedge aclk);
      step(k);
      p += clk_en.cpu_clk_en;
    end
    `CHK(p + 1 >= k, 1'b1)
    `CHK(k <= 132, 1'b1)
    p = 0;
    repeat (64) begin
      @(negedge aclk);
      p += clk_en.cpu_clk_en;
    end
    `CHK(p, 8)
    wr(IDX_IRQ_CLR, 32'h1);
    `CHK(irq, 1'b0)
    wr(IDX_CPU_SEL, 32'h0);
    cyc(140);
    rd({IDX_IRQ_FLAG, ADDR_LSB});
    `CHK({irq, d[0]}, 2'b01)
    wr(IDX_IRQ_FLAG, 32'h1);
    rd({IDX_IRQ_FLAG, ADDR_LSB});
    `CHK(d[0], 1'b0)
  endtask
  task automatic t_idle();
    for (int lvl = 0; lvl < 3; lvl++) begin
      wr(IDX_SLEEP, lvl);
      pulse_wfi(5'h00);
      wait_mode(MODE_IDLE);
      cyc(3);
      `CHK(clk_en.fast_bus_clk_en, (lvl == 0) ? AHB_RESET : 6'h00)
      `CHK(clk_en.bus_a_clk_en, (lvl == 2) ? 7'h00 : APBA_RESET)
      @(posedge aclk);
      cfg <= (lvl == 2) ? 5'h04 : 5'h02;
      cyc(4);
      `CHK(ps.mode, (lvl == 0) ? MODE_ACTIVE : MODE_IDLE)
      @(posedge aclk);
      cfg <= 5'h07;
      wait_mode(MODE_ACTIVE);
      @(posedge aclk);
      cfg <= 5'h00;
    end
    wr(IDX_SLEEP, 32'h3);
    rd({IDX_SLEEP, ADDR_LSB});
    `CHK(d[1:0], 2'h2)
  endtask
  task automatic t_standby();
    pulse_wfi(5'h08);
    wait_mode(MODE_STANDBY);
    cyc(2);
    `CHK(ps.osc_run, 4'b0001)
    @(posedge aclk);
    oreq <= 4'b0010;
    generic_clock_unit_req <= 1'b1;
    cyc(3);
    `CHK({ps.osc_run, ps.generic_clock_unit_run, ps.mode}, {4'b0011, 1'b1, MODE_STANDBY})
    @(posedge aclk);
    generic_clock_unit_req <= 1'b0;
    cfg <= 5'h09;
    wait_mode(MODE_ACTIVE);
    @(posedge aclk);
    cfg <= 5'h10;
    ret_go <= 1'b1;
    @(posedge aclk);
    ret_go <= 1'b0;
    wait_mode(MODE_IDLE);
    @(posedge aclk);
    cfg <= 5'h01;
    wait_mode(MODE_ACTIVE);
    @(posedge aclk);
    cfg <= 5'h00;
  endtask
  task automatic t_causes();
    int unsigned bits[6];
    bits = '{RC_POR, RC_CORE_BOD, RC_SUPPLY_BOD, RC_EXT, RC_DOG, RC_SOFT};
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      src_sel <= 3'(i + 1);
      repeat (2) @(posedge aclk);
      src_sel <= 3'd0;
      rd({IDX_ORIGIN, ADDR_LSB});
      `CHK(d, 32'h1 << bits[i])
    end
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, wfi_go, ret_go, generic_clock_unit_req} = '0;
    {awaddr, araddr, wdata, src_sel, cfg, oreq, errors, num_checks} = '0;
    keep = 4'b0011;
    ondem = 4'b0010;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_masks();
    t_settle();
    t_idle();
    t_standby();
    t_causes();
    complete_run();
  end
endmodule
